// *** pwct_timer.sv ***
// Pulse width capture timer: 16-bit counter, four capture channels,
// shared overflow flag, sticky interrupt status and AXI4-Lite slave.
// Assumes capture inputs are asynchronous pins; counts on every aclk while count enable is set.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: Mode code 110 selects pulse width measurement
// RULE2: Counter increments once count enable set
// RULE3: Edge captures count, clears counter, interrupts
// RULE4: At FFFFH overflow interrupt, wrap, continue
// RULE5: Overflow sets flag, held until cleared
// RULE6: Flag bit 0, cleared by zero write
// RULE7: Software uses one trigger, others no edge
// RULE8: Live counter readable in read-only register
// RULE9: Free-running: four channels capture independently
// RULE10: One overflow flag shared by all channels
// RULE11: Software counts overflows for long intervals
// RULE12: Long intervals: slower clock or software counting
// RULE13: Width is count plus overflows times 10000H
// RULE14: Free-running width is difference of captures
// RULE15: Early trigger after enable may misbehave
// RULE16: Disabled counter holds zero, no events
// RULE17: Inputs synchronised before edge detection
module pwct_timer
  import pwct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] capture_input,
  output logic [3:0] capture_irq,
  output logic overflow_irq,
  output logic irq
);

  pwct_state_t q;
  pwct_state_t n;
  logic [3:0] edge_hit;

  // One edge qualifier per channel, fed from sync stages two and three
  pwct_edge_pick #(
    .CH(0)
  ) pwct_edge_pick_0 (
    .s_cur(q.s2),
    .s_prev(q.s3),
    .sel_all(q.edge_sel),
    .hit(edge_hit[0])
  );

  pwct_edge_pick #(
    .CH(1)
  ) pwct_edge_pick_1 (
    .s_cur(q.s2),
    .s_prev(q.s3),
    .sel_all(q.edge_sel),
    .hit(edge_hit[1])
  );

  pwct_edge_pick #(
    .CH(2)
  ) pwct_edge_pick_2 (
    .s_cur(q.s2),
    .s_prev(q.s3),
    .sel_all(q.edge_sel),
    .hit(edge_hit[2])
  );

  pwct_edge_pick #(
    .CH(3)
  ) pwct_edge_pick_3 (
    .s_cur(q.s2),
    .s_prev(q.s3),
    .sel_all(q.edge_sel),
    .hit(edge_hit[3])
  );

  // Register read mux; returns response and data
  function automatic logic [33:0] reg_read(
    input pwct_state_t s,
    input logic [7:0] addr
  );
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0000_0000;
    r = RESP_OKAY;
    case (addr)
      OFS_CTRL: begin
        d[CE_BIT] = s.ce;
      end
      OFS_MODE: begin
        d[2:0] = s.mode;
      end
      OFS_OPT: begin
        d[OVF_BIT] = s.ovf;
      end
      OFS_EDGE: begin
        d[7:0] = s.edge_sel;
      end
      OFS_CNT: begin
        d[15:0] = s.cnt; // RULE8
      end
      OFS_CAP0: begin
        d[15:0] = s.cap[0];
      end
      OFS_CAP1: begin
        d[15:0] = s.cap[1];
      end
      OFS_CAP2: begin
        d[15:0] = s.cap[2];
      end
      OFS_CAP3: begin
        d[15:0] = s.cap[3];
      end
      OFS_ISTS: begin
        d[4:0] = s.ists;
      end
      OFS_IMASK: begin
        d[4:0] = s.imask;
      end
      default: begin
        r = RESP_SLVERR;
      end
    endcase
    return {r, d};
  endfunction : reg_read

  // Writable offsets; counter and capture registers accept and ignore
  function automatic logic addr_mapped(input logic [7:0] addr);
    logic ok;
    case (addr)
      OFS_CTRL, OFS_MODE, OFS_OPT, OFS_EDGE, OFS_CNT: begin
        ok = 1'b1;
      end
      OFS_CAP0, OFS_CAP1, OFS_CAP2, OFS_CAP3: begin
        ok = 1'b1;
      end
      OFS_ISTS, OFS_IMASK: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : addr_mapped

  always_comb begin
    logic [3:0] hit;
    logic capturing;
    logic clear_cnt;
    logic ovf_evt;
    logic do_wr;
    logic lane0;
    logic [33:0] rd;
    hit = 4'h0;
    capturing = 1'b0;
    clear_cnt = 1'b0;
    ovf_evt = 1'b0;
    do_wr = 1'b0;
    lane0 = 1'b0;
    rd = '0;
    n = q;
    n.cap_irq = 4'h0;
    n.ovf_irq = 1'b0;

    // Two-stage synchroniser, then edge detect on stages two and three
    n.s1 = capture_input; // RULE17
    n.s2 = q.s1;
    n.s3 = q.s2;
    hit = edge_hit; // RULE17

    // Capture only in the two capture modes and only while enabled
    capturing = q.ce && (q.mode == MODE_FREE || q.mode == MODE_PULSE); // RULE16
    if (!capturing) begin
      hit = 4'h0;
    end
    clear_cnt = (q.mode == MODE_PULSE) && (hit != 4'h0); // RULE1

    // Counter; capture first cycle after enable stores zero
    if (!q.ce) begin
      n.cnt = CNT_ZERO; // RULE16
    end else if (clear_cnt) begin
      n.cnt = CNT_ZERO; // RULE3
    end else if (q.cnt == CNT_MAX) begin
      n.cnt = CNT_ZERO; // RULE4
      ovf_evt = 1'b1; // RULE4
    end else begin
      n.cnt = q.cnt + CNT_ONE; // RULE2
    end

    // Each channel latches the shared counter on its own edge
    for (int m = 0; m < NUM_CH; m++) begin
      if (hit[m]) begin
        n.cap[m] = q.cnt; // RULE3 RULE9 RULE15
        n.cap_irq[m] = 1'b1; // RULE3
      end
    end
    n.ovf_irq = ovf_evt; // RULE4

    // Write channel collection, either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Register write once both halves are held
    do_wr = q.aw_got && q.w_got && !q.bvalid;
    lane0 = q.wstrb[0];
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_mapped(q.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (lane0) begin
        case (q.waddr)
          OFS_CTRL: begin
            n.ce = q.wdata[CE_BIT];
          end
          OFS_MODE: begin
            n.mode = q.wdata[2:0];
          end
          OFS_OPT: begin
            if (!q.wdata[OVF_BIT]) begin
              n.ovf = 1'b0; // RULE6
            end
          end
          OFS_EDGE: begin
            n.edge_sel = q.wdata[7:0];
          end
          OFS_ISTS: begin
            n.ists = q.ists & ~q.wdata[4:0];
          end
          OFS_IMASK: begin
            n.imask = q.wdata[4:0];
          end
          default: begin
            n.ce = q.ce;
          end
        endcase
      end
    end

    // Hardware sets win over software clears
    if (ovf_evt) begin
      n.ovf = 1'b1; // RULE5 RULE10
    end
    n.ists = n.ists | {ovf_evt, hit};

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      rd = reg_read(q, s_axi_araddr);
      n.rvalid = 1'b1;
      n.rresp = rd[33:32];
      n.rdata = rd[31:0];
    end

    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    n.irq = (n.ists & n.imask) != 5'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_STATE;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign capture_irq = q.cap_irq;
  assign overflow_irq = q.ovf_irq;
  assign irq = q.irq;

endmodule : pwct_timer

// Edge qualifier for one capture channel, chosen by CH
module pwct_edge_pick
  import pwct_pkg::*;
#(
  parameter int CH = 0
)
(
  input wire logic [3:0] s_cur,
  input wire logic [3:0] s_prev,
  input wire logic [7:0] sel_all,
  output logic hit
);

  logic rise;
  logic fall;

  assign rise = s_cur[CH] & ~s_prev[CH];
  assign fall = ~s_cur[CH] & s_prev[CH];

  always_comb begin
    case (sel_all[2*CH +: 2])
      EDGE_NONE: begin
        hit = 1'b0;
      end
      EDGE_RISE: begin
        hit = rise;
      end
      EDGE_FALL: begin
        hit = fall;
      end
      EDGE_BOTH: begin
        hit = rise | fall;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule : pwct_edge_pick

`default_nettype wire

// *** pwct_pkg.sv ***
// Package for the pulse width capture timer: register map, field
// positions, reset values, mode and edge codes, and the state record.
// Assumes a 32-bit AXI4-Lite register bus with 8 decoded address bits.
`default_nettype none

package pwct_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_OPT = 8'h08;
  localparam logic [7:0] OFS_EDGE = 8'h0C;
  localparam logic [7:0] OFS_CNT = 8'h10;
  localparam logic [7:0] OFS_CAP0 = 8'h14;
  localparam logic [7:0] OFS_CAP1 = 8'h18;
  localparam logic [7:0] OFS_CAP2 = 8'h1C;
  localparam logic [7:0] OFS_CAP3 = 8'h20;
  localparam logic [7:0] OFS_ISTS = 8'h24;
  localparam logic [7:0] OFS_IMASK = 8'h28;

  // Field positions
  localparam int CE_BIT = 0;
  localparam int OVF_BIT = 0;
  localparam int OVF_IRQ_BIT = 4;

  // Reset values
  localparam logic RST_CE = 1'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [4:0] RST_IMASK = 5'h00;

  // Mode selection codes
  localparam logic [2:0] MODE_FREE = 3'h5;
  localparam logic [2:0] MODE_PULSE = 3'h6;

  // Edge selection codes, two bits per channel
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Counter limits
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ce;
    logic [2:0] mode;
    logic [7:0] edge_sel;
    logic ovf;
    logic [15:0] cnt;
    logic [3:0][15:0] cap;
    logic [4:0] ists;
    logic [4:0] imask;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] cap_irq;
    logic ovf_irq;
    logic irq;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pwct_state_t;

  localparam pwct_state_t RST_STATE = '0;

endpackage : pwct_pkg

`default_nettype wire

// *** pwct_properties.sv ***
// Checker for the capture timer: bus handshakes and event pulses.
// Sees only top-level ports; bound from the testbench.
`timescale 1ns/1ps
`default_nettype none
module pwct_props(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] capture_input,
  input wire logic [3:0] capture_irq,
  input wire logic overflow_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_due;
    ##2 s_axi_bvalid;
  endsequence
  a_write_resp: assert property (both_taken |-> resp_due)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted too early");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted too early");
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready)
    else $error("write ready not restored");
  a_ovf_pulse: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow pulse too long");
  a_cap_edge: assert property (|capture_irq |->
    (capture_irq & ~($past(capture_input, 3) ^ $past(capture_input, 4))) == 4'h0)
    else $error("capture without pin edge");
endmodule : pwct_props
`default_nettype wire

// *** pwct_pins.sv ***
// Pin model: drives the capture pins to the requested levels.
// Changes on the falling edge, away from the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module pwct_pins(
  input wire logic aclk,
  input wire logic [3:0] lvl,
  output logic [3:0] pin
);
  always @(negedge aclk) pin <= lvl;
endmodule : pwct_pins
`default_nettype wire

// *** pwct_tb.sv ***
// Testbench for the capture timer: AXI4-Lite tasks and pin stimulus.
// Assumes the package, pin model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t: got %0h", $time, a); end end
module testbench;
  import pwct_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, overflow_irq, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb, capture_input, capture_irq, lvl;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count, n_tests;
  pwct_timer pwct_timer_i(.*);
  pwct_pins pwct_pins_i(.aclk(aclk), .lvl(lvl), .pin(capture_input));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Channel m, or overflow when m is 4
  task automatic wait_ev(input int m);
    int k;
    for (k = 0; k < 70000; k++) begin
      @(posedge aclk);
      if (m < 4 ? capture_irq[m] : overflow_irq) break;
    end
    `CHK(k < 70000, 1'b1)
  endtask : wait_ev
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    lvl = 4'h0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(OFS_CNT);
    `CHK(d, 32'h0)
    rd(8'hFC);
    `CHK(r, RESP_SLVERR)
    wr(8'hFC, 32'h0);
    `CHK(r, RESP_SLVERR)
    $display("test reset done");
    wr(OFS_EDGE, 32'h01);
    `CHK(r, RESP_OKAY)
    wr(OFS_MODE, {29'h0, MODE_PULSE});
    wr(OFS_IMASK, 32'h01);
    wr(OFS_CTRL, 32'h01);
    rd(OFS_CNT);
    e = d;
    rd(OFS_CNT);
    `CHK(d > e, 1'b1)
    lvl[0] <= 1'b1;
    repeat (50) @(posedge aclk);
    lvl[0] <= 1'b0;
    repeat (50) @(posedge aclk);
    lvl[0] <= 1'b1;
    wait_ev(0);
    rd(OFS_CAP0);
    `CHK(d, 32'h63)
    `CHK(irq, 1'b1)
    wr(OFS_ISTS, 32'h1F);
    rd(OFS_ISTS);
    `CHK(irq, 1'b0)
    $display("test pulse width done");
    wr(OFS_MODE, {29'h0, MODE_FREE});
    wr(OFS_EDGE, 32'h3C);
    lvl[1] <= 1'b1;
    repeat (10) @(posedge aclk);
    lvl[2] <= 1'b1;
    wait_ev(2);
    rd(OFS_CAP0 + 8'h04);
    e = d;
    rd(OFS_CAP0 + 8'h08);
    `CHK(d[15:0] - e[15:0], 16'h000A)
    wr(OFS_EDGE, 32'h00);
    $display("test free running done");
    wr(OFS_MODE, {29'h0, MODE_PULSE});
    wr(OFS_ISTS, 32'h1F);
    wr(OFS_IMASK, 32'h00);
    wait_ev(4);
    rd(OFS_CNT);
    `CHK(d < 32'h40, 1'b1)
    rd(OFS_OPT);
    `CHK(d, 32'h01)
    rd(OFS_ISTS);
    `CHK(d, 32'h10)
    `CHK(irq, 1'b0)
    wr(OFS_IMASK, 32'h10);
    wr(OFS_OPT, 32'h01);
    rd(OFS_OPT);
    `CHK(d, 32'h01)
    `CHK(irq, 1'b1)
    wr(OFS_OPT, 32'h00);
    rd(OFS_OPT);
    `CHK(d, 32'h00)
    wr(OFS_ISTS, 32'h10);
    rd(OFS_ISTS);
    `CHK(irq, 1'b0)
    $display("test overflow done");
    wr(OFS_CTRL, 32'h00);
    wr(OFS_EDGE, 32'h01);
    lvl[0] <= 1'b0;
    repeat (5) @(posedge aclk);
    lvl[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_ISTS);
    `CHK(d, 32'h00)
    rd(OFS_CNT);
    `CHK(d, 32'h00)
    $display("test disabled done");
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end
endmodule : testbench
bind pwct_timer pwct_props pwct_props_i(.*);
`default_nettype wire
